// ---- spi_flags_pkg.sv ----
package spi_flags_pkg;

  // Register byte addresses
  localparam logic [7:0] live_flags_addr = 8'h00;
  localparam logic [7:0] irq_ack_addr = 8'h04;
  localparam logic [7:0] irq_enable_addr = 8'h08;
  localparam logic [7:0] masked_flags_addr = 8'h0c;
  localparam logic [7:0] frame_count_addr = 8'h10;

  // Live flag bit positions
  localparam int bit_active = 14;
  localparam int bit_select = 13;
  localparam int bit_first = 12;
  localparam int bit_tx_empty_soon = 11;
  localparam int bit_tx_empty = 10;
  localparam int bit_tx_full_soon = 9;
  localparam int bit_tx_full = 8;
  localparam int bit_rx_empty_soon = 7;
  localparam int bit_rx_empty = 6;
  localparam int bit_rx_full_soon = 5;
  localparam int bit_rx_full = 4;
  localparam int bit_starved = 3;
  localparam int bit_dropped = 2;
  localparam int bit_rx_count = 1;
  localparam int bit_tx_count = 0;

  // Acknowledge bit positions
  localparam int ack_select_end = 5;
  localparam int ack_starved = 3;
  localparam int ack_dropped = 2;
  localparam int ack_rx_ready = 1;
  localparam int ack_tx_finished = 0;
  localparam int ack_reserved = 4;

  localparam int irq_bits = 6;
  localparam logic [5:0] frame_count_reset = 6'h01;

  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;

  // Events reported by the surrounding controller, one-cycle pulses
  typedef struct packed {
    logic tx_frame_done;
    logic rx_frame_done;
    logic tx_word_needed;
    logic select_end;
  } core_events_t;

  // Live levels from the controller
  typedef struct packed {
    logic active;
    logic select_level;
    logic head_is_first;
    logic master_mode;
    logic [4:0] tx_level;
    logic [4:0] rx_level;
  } core_levels_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic pend_write;
    logic [7:0] pend_addr;
    logic [5:0] raw;
    logic [5:0] enable;
    logic [5:0] frame_count;
    logic [5:0] tx_frames;
    logic [5:0] rx_frames;
  } state_t;

endpackage

// ---- spi_status_and_interrupt_clear.sv ----
`timescale 1ns/100ps

// Notes on behaviour
// RULE1 - Bit 14 shows a frame shifting
// RULE2 - Bit 13 shows select level live
// RULE3 - Bit 12 marks first frame of packet
// RULE4 - Bits 10, 11 transmit empty and nearly
// RULE5 - Bits 8, 9 transmit full and nearly
// RULE6 - Bits 6, 7 receive empty and nearly
// RULE7 - Bits 4, 5 receive full and nearly
// RULE8 - Bit 3 transmit starved on empty queue
// RULE9 - Master shifts only with queued word
// RULE10 - Bit 2 received frame dropped when full
// RULE11 - Bit 1 frame count received
// RULE12 - Bit 0 frame count sent
// RULE13 - Status word computed live, never held
// RULE14 - Small variant reserves bits 31 to 12
// RULE15 - Acknowledge bits 2, 3 clear errors
// RULE16 - Acknowledge bit 1 clears receive ready
// RULE17 - Acknowledge bit 0 clears transmit done
// RULE18 - Acknowledge register reads zero, no effect
// RULE19 - Small variant reserves acknowledge bits 31:4
// RULE20 - Software reads masked word for cause
// RULE21 - Acknowledge bit 5 clears select end
// RULE22 - Masked bit is enable AND raw
module spi_status_and_interrupt_clear
  import spi_flags_pkg::*;
#(
  parameter int queue_depth = 16,
  parameter bit small_variant = 1'b0
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Controller
  input wire core_events_t events,
  input wire core_levels_t levels,
  output logic tx_start_allowed,
  output logic tx_pop,
  output logic rx_push,
  output logic irq
);

  // Field widths and parameter limits
  localparam int level_width = 5;
  localparam int count_width = 6;
  localparam int queue_depth_min = 2;
  localparam int queue_depth_max = (1 << level_width) - 1;
  localparam int pad_width = $bits(hrdata) - irq_bits;
  localparam logic [count_width-1:0] count_max = '1;
  localparam logic [count_width-1:0] count_zero = '0;
  localparam logic [count_width-1:0] count_one = count_width'(1);

  // Elaboration checks
  if (queue_depth < queue_depth_min || queue_depth > queue_depth_max) begin : g_bad_depth
    $error("queue_depth out of range");
  end
  if (irq_bits != ack_select_end + 1) begin : g_bad_irq_bits
    $error("irq_bits does not cover the acknowledge bits");
  end
  if (count_width != irq_bits) begin : g_bad_count_width
    $error("frame count and acknowledge widths differ");
  end
  if (live_flags_addr[1:0] != 2'h0 || irq_ack_addr[1:0] != 2'h0) begin : g_bad_align
    $error("register addresses must be word aligned");
  end

  // Queue level constants
  localparam logic [4:0] depth_c = 5'(queue_depth);
  localparam logic [4:0] one_c = 5'h01;
  localparam logic [4:0] zero_c = 5'h00;

  // Register values after reset
  localparam state_t state_reset = '{
    hrdata: '0,
    pend_write: 1'b0,
    pend_addr: '0,
    raw: '0,
    enable: '0,
    frame_count: frame_count_reset,
    tx_frames: '0,
    rx_frames: '0
  };

  // Fill flags of one queue
  typedef struct packed {
    logic empty_soon;
    logic empty;
    logic full_soon;
    logic full;
  } queue_flags_t;

  // One select line per register
  typedef struct packed {
    logic live_flags;
    logic irq_ack;
    logic irq_enable;
    logic masked_flags;
    logic frame_count;
  } reg_sel_t;

  // State and its next value
  state_t s_r;
  state_t s_nxt;

  // Status word and queue flags
  logic [31:0] live;
  queue_flags_t tx_q;
  queue_flags_t rx_q;
  logic tx_empty;
  logic rx_full;
  logic active_bit;
  logic select_bit;
  logic first_bit;
  logic rx_count_done;
  logic tx_count_done;

  // Queue strobes and qualified events
  logic tx_sent;
  logic rx_stored;
  logic starved_now;
  logic dropped_now;
  logic select_end_now;

  // Bus decode
  logic addr_phase;
  reg_sel_t addr_sel;
  reg_sel_t pend_sel;
  logic wr_enable;
  logic wr_count;
  logic wr_ack;
  logic [31:0] read_word;

  // Interrupt sources
  logic [irq_bits-1:0] ack;
  logic [irq_bits-1:0] set_src;
  logic [irq_bits-1:0] raw_next;
  logic [irq_bits-1:0] masked;
  logic [count_width-1:0] tx_count_next;
  logic [count_width-1:0] rx_count_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // Fill flags from a queue level
  function automatic queue_flags_t queue_flags(input logic [4:0] level);
    queue_flags_t f;
    f.empty_soon = (level == one_c);
    f.empty = (level == zero_c);
    f.full_soon = (level == depth_c - one_c);
    f.full = (level == depth_c);
    return f;
  endfunction

  // Register select from a byte address
  function automatic reg_sel_t reg_select(input logic [7:0] a);
    reg_sel_t r;
    r.live_flags = 1'b0;
    r.irq_ack = 1'b0;
    r.irq_enable = 1'b0;
    r.masked_flags = 1'b0;
    r.frame_count = 1'b0;
    if (hit(a, live_flags_addr)) begin
      r.live_flags = 1'b1;
    end else if (hit(a, irq_ack_addr)) begin
      r.irq_ack = 1'b1;
    end else if (hit(a, irq_enable_addr)) begin
      r.irq_enable = 1'b1;
    end else if (hit(a, masked_flags_addr)) begin
      r.masked_flags = 1'b1;
    end else if (hit(a, frame_count_addr)) begin
      r.frame_count = 1'b1;
    end
    return r;
  endfunction

  // Six-bit register in the low end of a bus word
  function automatic logic [31:0] low_field(input logic [irq_bits-1:0] v);
    return {{pad_width{1'b0}}, v};
  endfunction

  // Queue flags and qualified events
  assign tx_q = queue_flags(levels.tx_level);
  assign rx_q = queue_flags(levels.rx_level);
  assign tx_empty = tx_q.empty;
  assign rx_full = rx_q.full;
  assign starved_now = events.tx_word_needed && tx_empty && !levels.master_mode; // RULE8
  assign dropped_now = events.rx_frame_done && rx_full; // RULE10
  assign rx_count_done = (s_r.rx_frames >= s_r.frame_count) && !rx_q.empty; // RULE11
  assign tx_count_done = (s_r.tx_frames >= s_r.frame_count); // RULE12
  assign masked = s_r.enable & s_r.raw; // RULE22

  // Packet indications exist only on the larger variant
  if (small_variant) begin : g_small
    assign active_bit = 1'b0;
    assign select_bit = 1'b0;
    assign first_bit = 1'b0;
    assign select_end_now = 1'b0;
  end else begin : g_full
    assign active_bit = levels.active; // RULE1
    assign select_bit = levels.select_level; // RULE2
    assign first_bit = levels.head_is_first && !rx_q.empty; // RULE3
    assign select_end_now = events.select_end; // RULE21
  end

  // Bus decode
  assign addr_phase = hsel && hready && (htrans == htrans_nonseq);
  assign addr_sel = reg_select(haddr[7:0]);
  assign pend_sel = reg_select(s_r.pend_addr);
  assign wr_enable = s_r.pend_write && pend_sel.irq_enable;
  assign wr_count = s_r.pend_write && pend_sel.frame_count;
  assign wr_ack = s_r.pend_write && pend_sel.irq_ack;

  // Queue strobes
  assign tx_start_allowed = !levels.master_mode || !tx_empty; // RULE9
  assign tx_pop = events.tx_word_needed && !tx_empty;
  assign rx_push = events.rx_frame_done && !rx_full;
  assign tx_sent = events.tx_frame_done && !(levels.master_mode && tx_empty); // RULE9
  assign rx_stored = rx_push;

  // Live status word
  always_comb begin
    live = 32'h0000_0000;
    live[bit_tx_empty_soon] = tx_q.empty_soon; // RULE4
    live[bit_tx_empty] = tx_q.empty; // RULE4
    live[bit_tx_full_soon] = tx_q.full_soon; // RULE5
    live[bit_tx_full] = tx_q.full; // RULE5
    live[bit_rx_empty_soon] = rx_q.empty_soon; // RULE6
    live[bit_rx_empty] = rx_q.empty; // RULE6
    live[bit_rx_full_soon] = rx_q.full_soon; // RULE7
    live[bit_rx_full] = rx_q.full; // RULE7
    live[bit_starved] = starved_now; // RULE8 RULE13
    live[bit_dropped] = dropped_now; // RULE10 RULE13
    live[bit_rx_count] = rx_count_done; // RULE11 RULE13
    live[bit_tx_count] = tx_count_done; // RULE12 RULE13
    live[bit_active] = active_bit; // RULE1 RULE14
    live[bit_select] = select_bit; // RULE2 RULE14
    live[bit_first] = first_bit; // RULE3 RULE14
  end

  // Read data for the register named in the address phase
  always_comb begin
    read_word = 32'h0000_0000;
    if (addr_sel.live_flags) begin
      read_word = live;
    end else if (addr_sel.irq_ack) begin
      read_word = 32'h0000_0000; // RULE18
    end else if (addr_sel.irq_enable) begin
      read_word = low_field(s_r.enable);
    end else if (addr_sel.masked_flags) begin
      read_word = low_field(masked); // RULE20 RULE22
    end else if (addr_sel.frame_count) begin
      read_word = low_field(s_r.frame_count);
    end
  end

  // Acknowledge strobes from a write data phase
  always_comb begin
    ack = '0;
    if (wr_ack) begin
      ack = hwdata[irq_bits-1:0];
      ack[ack_reserved] = 1'b0;
      if (small_variant) begin
        ack[ack_select_end] = 1'b0; // RULE19
      end
    end
  end

  // Frame counters restart on acknowledge and stop at their top value
  always_comb begin
    tx_count_next = s_r.tx_frames;
    rx_count_next = s_r.rx_frames;
    if (ack[ack_tx_finished]) begin
      tx_count_next = count_zero; // RULE17
    end
    if (ack[ack_rx_ready]) begin
      rx_count_next = count_zero; // RULE16
    end
    if (tx_sent && tx_count_next != count_max) begin
      tx_count_next = tx_count_next + count_one;
    end
    if (rx_stored && rx_count_next != count_max) begin
      rx_count_next = rx_count_next + count_one;
    end
  end

  // Events that raise an interrupt source
  always_comb begin
    set_src = '0;
    set_src[ack_tx_finished] = tx_sent && (tx_count_next >= s_r.frame_count); // RULE12
    set_src[ack_rx_ready] = rx_stored && (rx_count_next >= s_r.frame_count); // RULE11
    set_src[ack_dropped] = dropped_now; // RULE10
    set_src[ack_starved] = starved_now; // RULE8
    set_src[ack_select_end] = select_end_now; // RULE21
  end

  // Each source: a set in the same cycle wins over its acknowledge
  for (genvar i = 0; i < irq_bits; i++) begin : g_raw
    if (i == ack_reserved) begin : g_hole
      assign raw_next[i] = 1'b0;
    end else begin : g_src
      assign raw_next[i] = set_src[i] || (s_r.raw[i] && !ack[i]); // RULE15 RULE16 RULE17 RULE21
    end
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.hrdata = 32'h0000_0000;
    // Write data phase
    if (wr_enable) begin
      s_nxt.enable = hwdata[irq_bits-1:0];
    end
    if (wr_count) begin
      s_nxt.frame_count = hwdata[count_width-1:0];
    end
    // Address phase
    s_nxt.pend_write = 1'b0;
    if (addr_phase) begin
      s_nxt.pend_write = hwrite;
      s_nxt.pend_addr = haddr[7:0];
      if (!hwrite) begin
        s_nxt.hrdata = read_word;
      end
    end
    // Counters and interrupt sources
    s_nxt.tx_frames = tx_count_next;
    s_nxt.rx_frames = rx_count_next;
    s_nxt.raw = raw_next; // RULE15 RULE16 RULE17 RULE21
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= state_reset;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign irq = |masked; // RULE22

endmodule

// ---- spi_flags_chk.sv ----
`timescale 1ns/100ps
module spi_flags_chk
  import spi_flags_pkg::*;
#(
  parameter int queue_depth = 16
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Controller
  input wire core_events_t events,
  input wire core_levels_t levels,
  input wire logic tx_start_allowed,
  input wire logic tx_pop,
  input wire logic rx_push
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_go = hsel && hready && htrans == htrans_nonseq && !hwrite;
  wire rd_live = rd_go && haddr[7:0] == live_flags_addr;
  AST_ACTIVE: assert property (rd_live |=> hrdata[14] == $past(levels.active))
    else $error("active bit wrong");
  AST_SELECT: assert property (rd_live |=> hrdata[13] == $past(levels.select_level))
    else $error("select bit wrong");
  AST_TX_EMPTY: assert property (rd_live |=> hrdata[10] == ($past(levels.tx_level) == 5'h00))
    else $error("tx empty bit wrong");
  AST_TX_FULL: assert property (rd_live |=> hrdata[8] == ($past(levels.tx_level) == queue_depth))
    else $error("tx full bit wrong");
  AST_ACK_READ: assert property (rd_go && haddr[7:0] == irq_ack_addr |=> hrdata == 32'h0)
    else $error("ack read not zero");
  AST_START: assert property (levels.master_mode && levels.tx_level == 5'h00 |-> !tx_start_allowed)
    else $error("start with empty queue");
  AST_PUSH: assert property (events.rx_frame_done && levels.rx_level == queue_depth |-> !rx_push)
    else $error("push into full queue");
  AST_POP: assert property (events.tx_word_needed && levels.tx_level == 5'h00 |-> !tx_pop)
    else $error("pop from empty queue");
endmodule

bind spi_status_and_interrupt_clear spi_flags_chk #(.queue_depth(queue_depth)) chk_u (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .events(events), .levels(levels), .tx_start_allowed(tx_start_allowed),
  .tx_pop(tx_pop), .rx_push(rx_push));

// ---- spi_core_model.sv ----
`timescale 1ns/100ps
module spi_core_model
  import spi_flags_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Queue strobes
  input wire logic tx_pop,
  input wire logic rx_push,
  // Controller side
  output core_events_t events = '0,
  output core_levels_t levels = '0
);
  // Queue levels follow the strobes
  always @(posedge hclk) begin
    if (tx_pop) begin
      levels.tx_level <= levels.tx_level - 5'h01;
    end
    if (rx_push) begin
      levels.rx_level <= levels.rx_level + 5'h01;
    end
  end
  task set(input core_levels_t l);
    @(posedge hclk);
    levels <= l;
  endtask
  task pulse(input core_events_t e);
    @(posedge hclk);
    events <= e;
    @(posedge hclk);
    events <= '0;
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import spi_flags_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, tx_start_allowed, tx_pop, rx_push, irq;
  core_events_t events;
  core_levels_t levels;
  int bad_count = 0;
  int checked = 0;
  core_levels_t lv[4] = '{14'h3a0f, 14'h0030, 14'h01e1, 14'h0400};
  logic [31:0] ex[4] = '{32'h7120, 32'h0810, 32'h0280, 32'h0440};
  core_events_t ev[5] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h1};
  logic [4:0] rl[5] = '{5'h00, 5'h00, 5'h10, 5'h00, 5'h00};
  int bt[5] = '{0, 1, 2, 3, 5};
  logic [31:0] lx[5] = '{32'h0441, 32'h0482, 32'h0410, 32'h0440, 32'h0440};
  always #10 hclk = ~hclk;
  spi_status_and_interrupt_clear dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize_word), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(events), .levels(levels),
    .tx_start_allowed(tx_start_allowed), .tx_pop(tx_pop), .rx_push(rx_push), .irq(irq));
  spi_core_model m_u (.hclk(hclk), .tx_pop(tx_pop), .rx_push(rx_push), .events(events), .levels(levels));
  task end_sim;
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= htrans_nonseq;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(live_flags_addr, 32'h0440);
    rd(irq_ack_addr, 32'h0);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m_u.set(lv[i]);
      rd(live_flags_addr, ex[i]);
    end
    chk({31'h0, tx_start_allowed}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      m_u.set(core_levels_t'({9'h0, rl[i]}));
      wr(irq_enable_addr, 32'h1 << bt[i]);
      m_u.pulse(ev[i]);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      rd(masked_flags_addr, 32'h1 << bt[i]);
      rd(live_flags_addr, lx[i]);
      wr(irq_ack_addr, 32'h1 << bt[i]);
      rd(masked_flags_addr, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    wr(frame_count_addr, 32'h2);
    rd(frame_count_addr, 32'h2);
    m_u.pulse(core_events_t'(4'h8));
    rd(live_flags_addr, 32'h0440);
    m_u.pulse(core_events_t'(4'h8));
    rd(live_flags_addr, 32'h0441);
    end_sim;
  end
endmodule
